// >>> shared/hpb_pkg.sv
// shared types and constants for the haptic playback and bridge guard
package hpb_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CORE_CLK_KHZ  = 25000;
	localparam int PIN_MIN_US    = 100;
	localparam int PIN_MIN_CYC   = (PIN_MIN_US * CORE_CLK_KHZ + 999) / 1000;
	localparam int WAKE_MAX_US   = 400;
	localparam int WAKE_MAX_CYC  = (WAKE_MAX_US * CORE_CLK_KHZ) / 1000;
	localparam int FAST_MAX_US   = 100;
	localparam int FAST_MAX_CYC  = (FAST_MAX_US * CORE_CLK_KHZ) / 1000;
	localparam int MS_UNIT       = 1;
	localparam int MS_CYC        = MS_UNIT * CORE_CLK_KHZ;
	localparam int HALF_US       = 2500;
	localparam int HALF_CYC      = (HALF_US * CORE_CLK_KHZ) / 1000;
	localparam int DEAD_CYC      = 2;
	localparam int IDLE_CYC      = 65536;

	// ----------------------------------------
	// field values and reset values
	// ----------------------------------------
	localparam logic [2:0] STRENGTH_OFF   = 3'h0;
	localparam logic [2:0] STRENGTH_NO_OC1 = 3'h1;
	localparam logic [2:0] STRENGTH_NO_OC3 = 3'h3;
	localparam logic [7:0] OT_HYST        = 8'h05;
	localparam logic       RESET_FLAG_RST = 1'b1;
	localparam int         NUM_WF         = 8;
	localparam int         NUM_STAGES     = 7;
	localparam int         TOG_PLAY       = 0;
	localparam int         TOG_HALT       = 1;
	localparam int         TOG_STAT_RD    = 2;
	localparam int         TOG_ACK_RST    = 3;

	typedef enum logic [1:0] {
		HPB_PM_FAST  = 2'h0,
		HPB_PM_SLEEP = 2'h1,
		HPB_PM_AUTO  = 2'h2
	} hpb_pm_t;

	// gray codes along idle, wake, pulse, gap
	typedef enum logic [2:0] {
		HPB_IDLE  = 3'h0,
		HPB_WAKE  = 3'h1,
		HPB_PULSE = 3'h3,
		HPB_GAP   = 3'h2,
		HPB_CGAP  = 3'h6
	} hpb_state_t;

	typedef struct packed {
		logic        slew_en;
		logic [1:0]  slew_rate;
		logic [2:0]  strength;
		logic        oc_en;
		logic        ot_en;
		logic        hyst;
		logic        guard;
		logic        gnd_idle;
		logic        ext;
		logic        strict;
		logic        trig_level;
		logic        continuous;
		hpb_pm_t     power_mode;
		logic [15:0] cont_rep_ms;
	} hpb_cfg_t;

	typedef struct packed {
		logic [7:0] halves;
		logic [7:0] rep_count;
		logic [7:0] rep_ms;
	} hpb_wf_t;

	typedef struct packed {
		logic p_hi;
		logic p_lo;
		logic m_hi;
		logic m_lo;
	} hpb_gates_t;

endpackage

// >>> src/hpb_sync2.sv
// two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
module hpb_sync2 #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_b,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_q;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_q <= '0;
			o_sync <= '0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule

// >>> src/hpb_haptic_ctrl.sv
// haptic playback sequencer, trigger pin handling and bridge guard
`timescale 1ns/1ps
// Contract
// [RULE1] slew limit enable applies selected slew rate
// [RULE2] strength sets active stages; zero disables bridge
// [RULE3] no overcurrent protection at strength 1, 3
// [RULE4] ground idle outputs when idle, not sleeping; in external mode the code leaves all gates off instead
// [RULE5] enabled fault disables bridge while present
// [RULE6] overcurrent trips protection and sets flag
// [RULE7] fault flags sticky until status read
// [RULE8] temperature above threshold sets overtemp flag
// [RULE9] hysteresis keeps overtemp trip clean
// [RULE10] guard stops both leg transistors conducting together
// [RULE11] external bridge: drive one half only
// [RULE12] host disables resonance tracking in external mode
// [RULE13] eight stored waveforms, selected by index
// [RULE14] running flag held for whole waveform
// [RULE15] play while running is ignored
// [RULE16] play bit clears at every waveform start
// [RULE17] halt stops at once, else no effect
// [RULE18] host holds pin high 100 us to start
// [RULE19] start within 400 or 100 us
// [RULE20] edge mode: rising edge stops playback
// [RULE21] level mode: falling edge stops playback
// [RULE22] continuous mode repeats after interval until halt
// [RULE23] each repetition replays whole waveform
// [RULE24] running stays set across continuous gaps
// [RULE25] no deepest sleep while pin high
// [RULE26] unacknowledged reset flag blocks play requests
// [RULE27] strict mode needs both fault flags clear
// [RULE28] pin width qualified by counter while idle
module hpb_haptic_ctrl #(
	parameter int WAKE_CYC  = hpb_pkg::WAKE_MAX_CYC,
	parameter int FAST_CYC  = hpb_pkg::FAST_MAX_CYC,
	parameter int MS_CYC    = hpb_pkg::MS_CYC,
	parameter int HALF_CYC  = hpb_pkg::HALF_CYC,
	parameter int IDLE_CYC  = hpb_pkg::IDLE_CYC,
	parameter int PIN_CYC   = hpb_pkg::PIN_MIN_CYC
) (
	input  wire logic              i_core_clk,
	input  wire logic              i_rst_b,
	input  wire logic              i_link_clk,
	input  wire logic              i_link_play,
	input  wire logic              i_link_halt,
	input  wire logic              i_link_stat_rd,
	input  wire logic              i_link_ack_rst,
	input  wire logic [2:0]        i_link_wf_sel,
	input  wire logic              i_playback_trigger_pin,
	input  wire logic              i_oc_detect,
	input  wire logic [7:0]        i_die_temp,
	input  wire logic [7:0]        i_ot_thresh,
	input  wire hpb_pkg::hpb_cfg_t i_cfg,
	input  wire logic              i_wf_we,
	input  wire logic [2:0]        i_wf_idx,
	input  wire hpb_pkg::hpb_wf_t  i_wf_data,
	output hpb_pkg::hpb_gates_t    o_gates,
	output logic [6:0]             o_stage_en,
	output logic                   o_slew_en,
	output logic [1:0]             o_slew_rate,
	output logic                   o_running,
	output logic                   o_play_pending,
	output logic                   o_overcurrent,
	output logic                   o_overtemp,
	output logic                   o_reset_flag,
	output logic                   o_deepest_sleep
);
	import hpb_pkg::*;

	// refuse counts that the 16 bit counters cannot hold
	if (WAKE_CYC < 1 || FAST_CYC < 1 || MS_CYC < 1 || HALF_CYC < 1 ||
		IDLE_CYC < 1 || PIN_CYC < 1 || WAKE_CYC > 65535 || HALF_CYC > 65535 ||
		FAST_CYC > 65535 || PIN_CYC > 65535) begin : g_bad_timing
		$error("hpb_haptic_ctrl: timing parameter out of range");
	end

	// ----------------------------------------
	// link side: request toggles
	// ----------------------------------------
	logic [3:0] tog_link_q;
	logic [2:0] sel_link_q;

	always_ff @(posedge i_link_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tog_link_q <= 4'h0;
			sel_link_q <= 3'h0;
		end else begin
			tog_link_q <= tog_link_q ^ {i_link_ack_rst, i_link_stat_rd,
				i_link_halt, i_link_play};
			if (i_link_play) begin
				sel_link_q <= i_link_wf_sel;
			end
		end
	end

	// ----------------------------------------
	// crossings into the core clock
	// ----------------------------------------
	logic [3:0] tog_s;
	logic [3:0] tog_prev_q;
	logic [3:0] ev;
	logic [1:0] pin_s;
	logic       trig_s;
	logic       oc_s;

	hpb_sync2 #(.W(4)) u_sync_tog (
		.i_clk   (i_core_clk),
		.i_rst_b (i_rst_b),
		.i_async (tog_link_q),
		.o_sync  (tog_s)
	);

	hpb_sync2 #(.W(2)) u_sync_pin (
		.i_clk   (i_core_clk),
		.i_rst_b (i_rst_b),
		.i_async ({i_oc_detect, i_playback_trigger_pin}),
		.o_sync  (pin_s)
	);

	assign trig_s = pin_s[0];
	assign oc_s   = pin_s[1];
	assign ev     = tog_s ^ tog_prev_q;

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tog_prev_q <= 4'h0;
		end else begin
			tog_prev_q <= tog_s;
		end
	end

	// ----------------------------------------
	// waveform store
	// ----------------------------------------
	hpb_wf_t wf_mem [NUM_WF];
	hpb_wf_t wf_q;

	// [RULE13] eight entry store
	always_ff @(posedge i_core_clk) begin
		if (i_wf_we) begin
			wf_mem[i_wf_idx] <= i_wf_data;
		end
	end

	// ----------------------------------------
	// protection flags
	// ----------------------------------------
	logic oc_eff;
	logic ot_over_q;
	logic ot_now;
	logic fault_now;

	// [RULE3] strength gates overcurrent
	assign oc_eff = i_cfg.oc_en && (i_cfg.strength != STRENGTH_NO_OC1) &&
		(i_cfg.strength != STRENGTH_NO_OC3);

	// [RULE9] one-way hysteresis on release
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ot_over_q <= 1'b0;
		end else if (i_die_temp > i_ot_thresh) begin
			ot_over_q <= 1'b1;
		end else if (!i_cfg.hyst || (9'(i_die_temp) + 9'(OT_HYST) <= 9'(i_ot_thresh)) ||
			(i_ot_thresh < OT_HYST)) begin
			ot_over_q <= 1'b0;
		end
	end

	// [RULE8] compare against threshold
	assign ot_now    = i_cfg.ot_en && ot_over_q;
	assign fault_now = (oc_eff && oc_s) || ot_now;

	// [RULE7] sticky, set wins over read clear
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_overcurrent <= 1'b0;
			o_overtemp    <= 1'b0;
		end else begin
			// [RULE6] overcurrent sets flag
			o_overcurrent <= (oc_eff && oc_s) || (o_overcurrent && !ev[TOG_STAT_RD]);
			o_overtemp    <= ot_now || (o_overtemp && !ev[TOG_STAT_RD]);
		end
	end

	// ----------------------------------------
	// reset indication
	// ----------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_reset_flag <= RESET_FLAG_RST;
		end else if (ev[TOG_ACK_RST]) begin
			o_reset_flag <= 1'b0;
		end
	end

	// ----------------------------------------
	// trigger pin qualification
	// ----------------------------------------
	hpb_state_t st_q;
	logic [15:0] pin_cnt_q;
	logic        pin_done_q;
	logic        trig_prev_q;
	logic        pin_start;
	logic        pin_stop;
	logic        running;

	assign running = (st_q != HPB_IDLE);

	// [RULE28] count high time while idle
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pin_cnt_q   <= 16'h0000;
			pin_done_q  <= 1'b0;
			trig_prev_q <= 1'b0;
		end else begin
			trig_prev_q <= trig_s;
			if (!trig_s || running) begin
				pin_cnt_q  <= 16'h0000;
				pin_done_q <= trig_s;
			end else if (!pin_done_q) begin
				pin_cnt_q  <= pin_cnt_q + 16'h0001;
				pin_done_q <= (pin_cnt_q + 16'h0001 >= 16'(PIN_CYC));
			end
		end
	end

	// [RULE18] start after minimum width
	assign pin_start = trig_s && !running && !pin_done_q &&
		(pin_cnt_q + 16'h0001 >= 16'(PIN_CYC));

	// [RULE20] edge mode stop on rise
	// [RULE21] level mode stop on fall
	assign pin_stop = running && (i_cfg.trig_level ? (trig_prev_q && !trig_s) :
		(!trig_prev_q && trig_s));

	// ----------------------------------------
	// play and halt requests
	// ----------------------------------------
	logic start_ok;
	logic start;
	logic halt;

	// [RULE15] ignore while running
	// [RULE26] ignore until reset acknowledged
	// [RULE27] strict mode needs clean flags
	assign start_ok = !running && !o_reset_flag &&
		!(i_cfg.strict && (o_overcurrent || o_overtemp));
	assign start    = start_ok && (ev[TOG_PLAY] || pin_start);
	// [RULE17] halt only acts when running
	assign halt     = running && (ev[TOG_HALT] || pin_stop);

	// [RULE16] play bit clears at start
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_play_pending <= 1'b0;
		end else if (ev[TOG_PLAY] && !start) begin
			o_play_pending <= !start_ok && !running;
		end else if (start) begin
			o_play_pending <= 1'b0;
		end
	end

	// ----------------------------------------
	// power state
	// ----------------------------------------
	logic [31:0] idle_cnt_q;
	logic        sleep_want;

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			idle_cnt_q <= 32'h0000_0000;
		end else if (running || trig_s || (|ev)) begin
			idle_cnt_q <= 32'h0000_0000;
		end else if (idle_cnt_q < 32'(IDLE_CYC)) begin
			idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
		end
	end

	// [RULE25] pin high forces awake
	assign sleep_want = !running && !trig_s && ((i_cfg.power_mode == HPB_PM_SLEEP) ||
		((i_cfg.power_mode == HPB_PM_AUTO) && (idle_cnt_q >= 32'(IDLE_CYC))));

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_deepest_sleep <= 1'b0;
		end else begin
			o_deepest_sleep <= sleep_want;
		end
	end

	// ----------------------------------------
	// playback sequencer
	// ----------------------------------------
	logic [15:0] cnt_q;
	logic [31:0] pre_q;
	logic [15:0] ms_q;
	logic [7:0]  half_q;
	logic [7:0]  rep_q;
	logic        dir_q;
	logic        tick;
	logic        half_end;

	assign tick     = (pre_q + 32'h0000_0001 >= 32'(MS_CYC));
	assign half_end = (cnt_q + 16'h0001 >= 16'(HALF_CYC));

	// [RULE14] running held through waveform
	// [RULE24] running held across gaps
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q   <= HPB_IDLE;
			cnt_q  <= 16'h0000;
			pre_q  <= 32'h0000_0000;
			ms_q   <= 16'h0000;
			half_q <= 8'h00;
			rep_q  <= 8'h00;
			dir_q  <= 1'b0;
			wf_q   <= '0;
		end else if (halt) begin
			st_q <= HPB_IDLE;
		end else begin
			case (st_q)
				HPB_IDLE: begin
					if (start) begin
						// [RULE13] pick selected waveform
						wf_q  <= wf_mem[sel_link_q];
						// [RULE19] start delay by power state
						cnt_q <= o_deepest_sleep ? 16'(WAKE_CYC - 1) : 16'(FAST_CYC - 1);
						st_q  <= HPB_WAKE;
					end
				end
				HPB_WAKE: begin
					if (cnt_q == 16'h0000) begin
						rep_q  <= (wf_q.rep_count == 8'h00) ? 8'h01 : wf_q.rep_count;
						half_q <= wf_q.halves;
						dir_q  <= 1'b0;
						st_q   <= HPB_PULSE;
					end else begin
						cnt_q <= cnt_q - 16'h0001;
					end
				end
				HPB_PULSE: begin
					if (!half_end) begin
						cnt_q <= cnt_q + 16'h0001;
					end else begin
						cnt_q <= 16'h0000;
						dir_q <= !dir_q;
						if (half_q > 8'h01) begin
							half_q <= half_q - 8'h01;
						end else if (rep_q > 8'h01) begin
							rep_q  <= rep_q - 8'h01;
							half_q <= wf_q.halves;
							dir_q  <= 1'b0;
							pre_q  <= 32'h0000_0000;
							ms_q   <= {8'h00, wf_q.rep_ms};
							st_q   <= (wf_q.rep_ms == 8'h00) ? HPB_PULSE : HPB_GAP;
						end else if (i_cfg.continuous) begin
							// [RULE22] repeat after interval
							// [RULE23] full waveform again
							rep_q  <= (wf_q.rep_count == 8'h00) ? 8'h01 : wf_q.rep_count;
							half_q <= wf_q.halves;
							dir_q  <= 1'b0;
							pre_q  <= 32'h0000_0000;
							ms_q   <= i_cfg.cont_rep_ms;
							st_q   <= (i_cfg.cont_rep_ms == 16'h0000) ? HPB_PULSE : HPB_CGAP;
						end else begin
							st_q <= HPB_IDLE;
						end
					end
				end
				HPB_GAP, HPB_CGAP: begin
					// last tick ends the gap, so a gap is exactly n ms long
					if (!tick) begin
						pre_q <= pre_q + 32'h0000_0001;
					end else begin
						pre_q <= 32'h0000_0000;
						ms_q  <= ms_q - 16'h0001;
						if (ms_q <= 16'h0001) begin
							st_q <= HPB_PULSE;
						end
					end
				end
				default: begin
					st_q <= HPB_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_running <= 1'b0;
		end else begin
			o_running <= running && !halt;
		end
	end

	// ----------------------------------------
	// bridge output stage
	// ----------------------------------------
	logic [2:0] dead_q;
	logic       dir_prev_q;
	logic       drive;
	hpb_gates_t gates_d;

	// [RULE10] dead time after each reversal
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			dead_q     <= 3'h0;
			dir_prev_q <= 1'b0;
		end else begin
			dir_prev_q <= dir_q;
			if (i_cfg.guard && (dir_prev_q != dir_q)) begin
				dead_q <= 3'(DEAD_CYC);
			end else if (dead_q != 3'h0) begin
				dead_q <= dead_q - 3'h1;
			end
		end
	end

	// [RULE2] zero strength blocks drive
	// [RULE5] fault present blocks drive
	assign drive = (st_q == HPB_PULSE) && (i_cfg.strength != STRENGTH_OFF) &&
		!fault_now && (dead_q == 3'h0) && !(i_cfg.guard && (dir_prev_q != dir_q));

	always_comb begin
		gates_d = '0;
		if (i_cfg.ext) begin
			// [RULE11] one half only, external inverts
			gates_d.p_hi = drive && !dir_q;
			gates_d.m_hi = drive && dir_q;
		end else if (drive) begin
			gates_d.p_hi = !dir_q;
			gates_d.m_lo = !dir_q;
			gates_d.m_hi = dir_q;
			gates_d.p_lo = dir_q;
		end else if ((st_q == HPB_IDLE) && i_cfg.gnd_idle && !o_deepest_sleep &&
			(i_cfg.strength != STRENGTH_OFF)) begin
			// [RULE4] pull both outputs low
			gates_d.p_lo = 1'b1;
			gates_d.m_lo = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_gates     <= '0;
			o_stage_en  <= 7'h00;
			o_slew_en   <= 1'b0;
			o_slew_rate <= 2'h0;
		end else begin
			o_gates <= gates_d;
			// [RULE2] thermometer of stages
			for (int i = 0; i < NUM_STAGES; i++) begin
				o_stage_en[i] <= (32'(i) < 32'(i_cfg.strength));
			end
			// [RULE1] slew limit follows settings
			o_slew_en   <= i_cfg.slew_en;
			o_slew_rate <= i_cfg.slew_en ? i_cfg.slew_rate : 2'h0;
		end
	end
endmodule

// >>> bench/hpb_haptic_ctrl_sva.sv
// port assertions for the haptic playback sequencer
`timescale 1ns/1ps
module hpb_haptic_ctrl_sva (
	input wire logic                i_core_clk,
	input wire logic                i_rst_b,
	input wire logic                i_link_halt,
	input wire logic                i_link_stat_rd,
	input wire logic                i_playback_trigger_pin,
	input wire logic [7:0]          i_die_temp,
	input wire logic [7:0]          i_ot_thresh,
	input wire hpb_pkg::hpb_cfg_t   i_cfg,
	input wire hpb_pkg::hpb_gates_t o_gates,
	input wire logic [6:0]          o_stage_en,
	input wire logic                o_slew_en,
	input wire logic [1:0]          o_slew_rate,
	input wire logic                o_running,
	input wire logic                o_overcurrent,
	input wire logic                o_overtemp,
	input wire logic                o_reset_flag,
	input wire logic                o_deepest_sleep
);
	import hpb_pkg::*;
	logic [1:0] up_q;
	logic [3:0] rd_age_q;
	logic [3:0] stop_age_q;
	logic       pin_q;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			up_q <= 2'h0;
		else if (up_q != 2'h3)
			up_q <= up_q + 2'h1;
	end
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			rd_age_q <= 4'hf;
		else if (i_link_stat_rd)
			rd_age_q <= 4'h0;
		else if (rd_age_q != 4'hf)
			rd_age_q <= rd_age_q + 4'h1;
	end
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			stop_age_q <= 4'hf;
			pin_q <= 1'b0;
		end else begin
			pin_q <= i_playback_trigger_pin;
			if (i_link_halt || i_playback_trigger_pin != pin_q)
				stop_age_q <= 4'h0;
			else if (stop_age_q != 4'hf)
				stop_age_q <= stop_age_q + 4'h1;
		end
	end
	sequence s_ot_hot;
		i_cfg.ot_en && i_die_temp > i_ot_thresh;
	endsequence
	sequence s_idle_gnd;
		i_cfg.gnd_idle && !i_cfg.ext && !i_cfg.oc_en && !i_cfg.ot_en && !o_running
			&& !o_deepest_sleep && i_cfg.strength != 3'h0;
	endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	stage_map_a: assert property (
		up_q == 2'h3 |-> o_stage_en == 7'((8'h1 << $past(i_cfg.strength)) - 8'h1)
	) else $error("stage enables wrong");
	slew_map_a: assert property (
		up_q == 2'h3 |-> o_slew_en == $past(i_cfg.slew_en)
			&& o_slew_rate == ($past(i_cfg.slew_en) ? $past(i_cfg.slew_rate) : 2'h0)
	) else $error("slew outputs wrong");
	leg_guard_a: assert property (
		i_cfg.guard |-> !(o_gates.p_hi && o_gates.p_lo) && !(o_gates.m_hi && o_gates.m_lo)
	) else $error("both transistors of a leg on");
	ot_trip_a: assert property (
		s_ot_hot [*3] |-> o_overtemp
	) else $error("overtemp flag not set");
	drive_cut_a: assert property (
		s_ot_hot [*3] |-> !o_gates.p_hi && !o_gates.m_hi
	) else $error("drive on during fault");
	oc_blind_a: assert property (
		$rose(o_overcurrent) |-> $past(i_cfg.oc_en) && $past(i_cfg.strength) != 3'h1
			&& $past(i_cfg.strength) != 3'h3
	) else $error("overcurrent set while inactive");
	flag_sticky_a: assert property (
		$fell(o_overcurrent) || $fell(o_overtemp) |-> rd_age_q < 4'h8
	) else $error("fault flag cleared without read");
	cont_hold_a: assert property (
		$fell(o_running) && i_cfg.continuous |-> stop_age_q < 4'hc
	) else $error("continuous run ended without stop");
	pin_wake_a: assert property (
		i_playback_trigger_pin [*4] |-> !$rose(o_deepest_sleep)
	) else $error("deepest sleep with pin high");
	rst_block_a: assert property (
		o_reset_flag [*8] |-> !$rose(o_running)
	) else $error("start under reset flag");
	idle_gnd_a: assert property (
		s_idle_gnd [*3] |-> o_gates.p_lo && o_gates.m_lo && !o_gates.p_hi && !o_gates.m_hi
	) else $error("idle outputs not grounded");
endmodule

bind hpb_haptic_ctrl hpb_haptic_ctrl_sva u_sva (
	.i_core_clk, .i_rst_b, .i_link_halt, .i_link_stat_rd, .i_playback_trigger_pin,
	.i_die_temp, .i_ot_thresh, .i_cfg, .o_gates, .o_stage_en, .o_slew_en, .o_slew_rate,
	.o_running, .o_overcurrent, .o_overtemp, .o_reset_flag, .o_deepest_sleep
);

// >>> bench/hpb_host_model.sv
// host side model: link request pulses and the trigger pin
`timescale 1ns/1ps
module hpb_host_model (
	input  wire logic i_link_clk,
	input  wire logic i_core_clk,
	output logic      o_play,
	output logic      o_halt,
	output logic      o_stat_rd,
	output logic      o_ack_rst,
	output logic [2:0] o_sel,
	output logic      o_pin
);
	import hpb_pkg::*;
	initial begin
		{o_play, o_halt, o_stat_rd, o_ack_rst, o_sel, o_pin} = '0;
	end
	// patterns carry no tracking
	// spacing first, then one link cycle pulse; sel held until the next play
	task automatic req(input int k, input logic [2:0] s);
		repeat (3) @(negedge i_link_clk);
		if (k == TOG_PLAY)
			o_sel = s;
		o_play = (k == TOG_PLAY);
		o_halt = (k == TOG_HALT);
		o_stat_rd = (k == TOG_STAT_RD);
		o_ack_rst = (k == TOG_ACK_RST);
		@(negedge i_link_clk);
		{o_play, o_halt, o_stat_rd, o_ack_rst} = '0;
	endtask
	task automatic pin(input int n);
		@(negedge i_core_clk);
		o_pin = 1'b1;
		repeat (n) @(negedge i_core_clk);
		o_pin = 1'b0;
	endtask
endmodule

// >>> bench/hpb_haptic_ctrl_tb.sv
// self-checking bench for the haptic playback sequencer
`timescale 1ns/1ps
module hpb_haptic_ctrl_tb;
	import hpb_pkg::*;
	localparam int HC = 8;
	localparam int MC = 10;
	localparam int PC = 4;
	logic i_core_clk, i_link_clk, i_rst_b, i_oc_detect, i_wf_we;
	logic i_link_play, i_link_halt, i_link_stat_rd, i_link_ack_rst, i_playback_trigger_pin;
	logic [2:0] i_link_wf_sel, i_wf_idx;
	logic [7:0] i_die_temp, i_ot_thresh;
	hpb_cfg_t i_cfg;
	hpb_wf_t i_wf_data;
	hpb_gates_t o_gates;
	logic [6:0] o_stage_en;
	logic [1:0] o_slew_rate;
	logic o_slew_en, o_running, o_play_pending, o_overcurrent, o_overtemp;
	logic o_reset_flag, o_deepest_sleep;
	int errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int d, d1, d5;
	hpb_haptic_ctrl #(.WAKE_CYC(20), .FAST_CYC(5), .MS_CYC(MC), .HALF_CYC(HC),
		.IDLE_CYC(50), .PIN_CYC(PC)) DUT (
		.i_core_clk, .i_rst_b, .i_link_clk, .i_link_play, .i_link_halt, .i_link_stat_rd,
		.i_link_ack_rst, .i_link_wf_sel, .i_playback_trigger_pin, .i_oc_detect, .i_die_temp,
		.i_ot_thresh, .i_cfg, .i_wf_we, .i_wf_idx, .i_wf_data, .o_gates, .o_stage_en,
		.o_slew_en, .o_slew_rate, .o_running, .o_play_pending, .o_overcurrent, .o_overtemp,
		.o_reset_flag, .o_deepest_sleep);
	hpb_host_model host (.i_link_clk, .i_core_clk, .o_play(i_link_play),
		.o_halt(i_link_halt), .o_stat_rd(i_link_stat_rd), .o_ack_rst(i_link_ack_rst),
		.o_sel(i_link_wf_sel), .o_pin(i_playback_trigger_pin));
	initial begin
		i_core_clk = 1'b0;
		forever #20 i_core_clk = ~i_core_clk;
	end
	initial begin
		i_link_clk = 1'b0;
		#7;
		forever #24 i_link_clk = ~i_link_clk;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic results;
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic chk_d(input string n, input int e, input int g);
		n_tests++;
		if (g != e) begin
			errors++;
			$display("MISMATCH %s expected %0d seen %0d", n, e, g);
		end
	endtask
	task automatic tk(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask
	// cycles of running, after a bounded wait for its start
	task automatic dur(output int t);
		int w;
		w = 0;
		t = 0;
		while (o_running !== 1'b1 && w < 60) begin
			tk(1);
			w++;
		end
		while (o_running === 1'b1 && t < 4000) begin
			tk(1);
			t++;
		end
	endtask
	task automatic wr(input logic [2:0] k, input logic [7:0] h, r, m);
		tk(1);
		i_wf_we = 1'b1;
		i_wf_idx = k;
		i_wf_data = {h, r, m};
		tk(1);
		i_wf_we = 1'b0;
	endtask
	task automatic run_wf(input logic [2:0] k, output int t);
		host.req(TOG_PLAY, k);
		dur(t);
	endtask
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			results();
		end
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		i_rst_b = 1'b0;
		{i_oc_detect, i_wf_we, i_wf_idx, i_wf_data, i_cfg} = '0;
		i_die_temp = 8'h20;
		i_ot_thresh = 8'h40;
		i_cfg.strength = 3'h5;
		i_cfg.guard = 1'b1;
		i_cfg.hyst = 1'b1;
		i_cfg.gnd_idle = 1'b1;
		i_cfg.power_mode = HPB_PM_FAST;
		tk(3);
		i_rst_b = 1'b1;
		tk(2);
		chk("reset flag", 1, o_reset_flag);
		wr(3'h1, 8'h2, 8'h1, 8'h0);
		wr(3'h5, 8'h4, 8'h1, 8'h0);
		wr(3'h2, 8'h2, 8'h2, 8'h1);
		host.req(TOG_PLAY, 3'h1);
		tk(30);
		chk("blocked run", 0, o_running);
		chk("pending", 1, o_play_pending);
		host.req(TOG_ACK_RST, 3'h0);
		tk(8);
		chk("ack", 0, o_reset_flag);
		run_wf(3'h1, d1);
		run_wf(3'h5, d5);
		chk_d("select", 2 * HC, d5 - d1);
		run_wf(3'h2, d);
		chk_d("one shot", 2 * HC + MC, d - d1);
		host.req(TOG_PLAY, 3'h5);
		fork
			dur(d);
			begin tk(12); host.req(TOG_PLAY, 3'h1); end
		join
		chk_d("ignored", d5, d);
		host.req(TOG_PLAY, 3'h5);
		fork
			dur(d);
			begin tk(12); host.req(TOG_HALT, 3'h0); end
		join
		chk("halt", 1, d < d5);
		host.req(TOG_HALT, 3'h0);
		tk(10);
		chk("idle halt", 0, o_running);
		run_wf(3'h5, d);
		chk_d("after halt", d5, d);
		host.pin(PC - 2);
		tk(20);
		chk("short pin", 0, o_running);
		fork dur(d); host.pin(PC + 2); join
		chk_d("pin start", d5, d);
		fork
			dur(d);
			begin host.pin(PC + 2); tk(12); host.pin(1); end
		join
		chk("edge stop", 1, d < d5);
		i_cfg.trig_level = 1'b1;
		fork dur(d); host.pin(PC + 14); join
		chk("level stop", 1, d < d5);
		fork dur(d); host.pin(3 * d5); join
		tk(10);
		chk_d("level late", d5, d);
		chk("no restart", 0, o_running);
		chk("gnd idle", 16'h5, {12'h0, o_gates});
		i_cfg.ext = 1'b1;
		tk(2);
		chk("ext idle", 16'h0, {12'h0, o_gates});
		i_cfg.ext = 1'b0;
		i_cfg.trig_level = 1'b0;
		i_cfg.continuous = 1'b1;
		i_cfg.cont_rep_ms = 16'h1;
		host.req(TOG_PLAY, 3'h1);
		fork
			dur(d);
			begin tk(4 * d1); host.req(TOG_HALT, 3'h0); end
		join
		chk("repeats", 1, d > 3 * d1);
		i_cfg.continuous = 1'b0;
		i_cfg.ot_en = 1'b1;
		i_die_temp = 8'h50;
		tk(5);
		chk("ot set", 1, o_overtemp);
		i_die_temp = 8'h20;
		tk(5);
		chk("ot held", 1, o_overtemp);
		i_cfg.strict = 1'b1;
		host.req(TOG_PLAY, 3'h1);
		tk(30);
		chk("strict", 0, o_running);
		host.req(TOG_STAT_RD, 3'h0);
		tk(10);
		chk("ot clear", 0, o_overtemp);
		i_cfg.strict = 1'b0;
		i_cfg.ot_en = 1'b0;
		i_cfg.oc_en = 1'b1;
		i_cfg.strength = 3'h3;
		i_oc_detect = 1'b1;
		tk(8);
		chk("oc blind", 0, o_overcurrent);
		i_cfg.strength = 3'h5;
		tk(8);
		chk("oc set", 1, o_overcurrent);
		i_oc_detect = 1'b0;
		i_cfg.oc_en = 1'b0;
		host.req(TOG_STAT_RD, 3'h0);
		tk(10);
		chk("oc clear", 0, o_overcurrent);
		for (int s = 0; s < 8; s++) begin
			i_cfg.strength = s[2:0];
			tk(2);
			chk("stages", (16'h1 << s) - 16'h1, {9'h0, o_stage_en});
		end
		i_cfg.slew_en = 1'b1;
		i_cfg.slew_rate = 2'h2;
		tk(2);
		chk("slew", 16'h6, {13'h0, o_slew_en, o_slew_rate});
		i_cfg.slew_en = 1'b0;
		tk(2);
		chk("slew off", 16'h0, {13'h0, o_slew_en, o_slew_rate});
		i_cfg.power_mode = HPB_PM_AUTO;
		tk(60);
		chk("sleep", 1, o_deepest_sleep);
		chk("sleep gates", 16'h0, {12'h0, o_gates});
		run_wf(3'h5, d);
		chk_d("wake", d5 + 20 - 5, d);
		chk("pend clr", 0, o_play_pending);
		results();
	end
endmodule
